// File: hw/xpbs_pkg.sv
// Constants for the receive bypass, clock-down and soft-reset register bank
package xpbs_pkg;
  localparam logic [15:0] XPBS_ADDR_BYPASS = 16'h801E;
  localparam logic [15:0] XPBS_ADDR_CLKDOWN = 16'h801F;
  localparam logic [15:0] XPBS_ADDR_SRESET = 16'h8020;
  localparam logic [15:0] XPBS_ADDR_PATTERN = 16'h8021;
  localparam logic [15:0] XPBS_BYPASS_RESET = 16'h0000;
  localparam logic [15:0] XPBS_BYPASS_MASK = 16'hCF88;
  localparam int XPBS_BIT_CLOCK_COMP = 15;
  localparam int XPBS_BIT_GAP_CHECK = 14;
  localparam int XPBS_BIT_DEC_LO = 8;
  localparam int XPBS_BIT_SEQ_IPG = 7;
  localparam int XPBS_BIT_ALIGN = 3;
  localparam int XPBS_BIT_TX_RST = 15;
  localparam int XPBS_BIT_RX_RST = 14;
  localparam int XPBS_BIT_MUX_RST = 13;
  localparam int XPBS_BIT_SYNC = 15;
  localparam logic [7:0] XPBS_FLAGS_RESET = 8'h00;
  localparam logic [7:0] XPBS_STALL_CYCLES = 8'hFF;
endpackage : xpbs_pkg

// File: hw/xpbs_regs.sv
// Receive bypass, clock-down, soft-reset and pattern-sync register bank
`timescale 1ns/1ps

// Overview of operation
// R1 - Clock compensation skip bit passes receive data
// R2 - Gap checker skip leaves codes, skips checks
// R3 - Four decoder skip bits, lane 3 highest
// R4 - Bit 7 counts sequence columns in gap
// R5 - Lane alignment skip bit disables deskew
// R6 - Latch flag when 312.5 MHz clock stalls
// R7 - Latch flag when 156 MHz clock stalls
// R8 - Transmit soft reset self-clears, keeps registers
// R9 - Receive soft reset self-clears, keeps registers
// R10 - Mux soft reset self-clears, keeps registers
// R11 - Sync flag reports test pattern preamble recovered
// R12 - Clock flags hold until read, then clear; a flag whose clock is still stalled stays set
// R13 - Undefined bits read zero, ignore writes
module xpbs_regs import xpbs_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic [3:0] tx_clk312_toggle_in,
  input wire logic [3:0] tx_clk156_toggle_in,
  input wire logic pattern_sync_in,
  output logic rx_clock_comp_skip_out,
  output logic gap_checker_skip_out,
  output logic [3:0] decoder_skip_out,
  output logic seq_in_gap_out,
  output logic align_skip_out,
  output logic tx_path_reset_out,
  output logic rx_path_reset_out,
  output logic retimer_mux_reset_out
);

  typedef struct packed {
    logic [15:0] bypass;
    logic [7:0] flags;
    logic [7:0] act_prev;
    logic [7:0][7:0] idle_cnt;
    logic [2:0] rst_pulse;
    logic [15:0] rdata;
    logic rvalid;
  } xpbs_state_t;

  xpbs_state_t st_ff;
  xpbs_state_t nxt_st;
  logic [7:0] act;
  logic [7:0] stalled;
  logic wr_bypass;
  logic wr_reset;
  logic rd_flags;

  assign act = {tx_clk312_toggle_in, tx_clk156_toggle_in};
  assign wr_bypass = reg_wr_in && (reg_addr_in == XPBS_ADDR_BYPASS);
  assign wr_reset = reg_wr_in && (reg_addr_in == XPBS_ADDR_SRESET);
  assign rd_flags = reg_rd_in && (reg_addr_in == XPBS_ADDR_CLKDOWN);

  always_comb begin
    nxt_st = st_ff;
    // R13 undefined bits dropped
    if (wr_bypass) begin
      nxt_st.bypass = reg_wdata_in & XPBS_BYPASS_MASK;
    end
    // R8 R9 R10 one-cycle pulses
    nxt_st.rst_pulse = 3'h0;
    if (wr_reset) begin
      nxt_st.rst_pulse = reg_wdata_in[XPBS_BIT_TX_RST:XPBS_BIT_MUX_RST];
    end
    // R6 R7 stall counters per clock
    for (int i = 0; i < 8; i++) begin
      nxt_st.act_prev[i] = act[i];
      if (act[i] != st_ff.act_prev[i]) begin
        nxt_st.idle_cnt[i] = 8'h00;
      end else if (st_ff.idle_cnt[i] != XPBS_STALL_CYCLES) begin
        nxt_st.idle_cnt[i] = st_ff.idle_cnt[i] + 8'h01;
      end
      stalled[i] = (st_ff.idle_cnt[i] == XPBS_STALL_CYCLES);
    end
    // R12 clear on read, set wins
    nxt_st.flags = (rd_flags ? 8'h00 : st_ff.flags) | stalled;
    nxt_st.rvalid = reg_rd_in;
    nxt_st.rdata = 16'h0000;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        XPBS_ADDR_BYPASS: nxt_st.rdata = st_ff.bypass;
        XPBS_ADDR_CLKDOWN: nxt_st.rdata = {8'h00, st_ff.flags};
        XPBS_ADDR_SRESET: nxt_st.rdata = {st_ff.rst_pulse, 13'h0000};
        // R11 sync flag readback
        XPBS_ADDR_PATTERN: nxt_st.rdata = {pattern_sync_in, 15'h0000};
        default: nxt_st.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_out = st_ff.rdata;
  assign reg_rvalid_out = st_ff.rvalid;
  // R1 clock compensation skip
  assign rx_clock_comp_skip_out = st_ff.bypass[XPBS_BIT_CLOCK_COMP];
  // R2 gap checker skip
  assign gap_checker_skip_out = st_ff.bypass[XPBS_BIT_GAP_CHECK];
  // R3 per-lane decoder skip
  assign decoder_skip_out = st_ff.bypass[XPBS_BIT_DEC_LO +: 4];
  // R4 sequence in gap
  assign seq_in_gap_out = st_ff.bypass[XPBS_BIT_SEQ_IPG];
  // R5 lane alignment skip
  assign align_skip_out = st_ff.bypass[XPBS_BIT_ALIGN];
  // R8 transmit reset pulse
  assign tx_path_reset_out = st_ff.rst_pulse[2];
  // R9 receive reset pulse
  assign rx_path_reset_out = st_ff.rst_pulse[1];
  // R10 mux reset pulse
  assign retimer_mux_reset_out = st_ff.rst_pulse[0];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // R1 skip follows write
  a_ctc_skip_set: assert property ( // R1
    wr_bypass |=> rx_clock_comp_skip_out == $past(reg_wdata_in[15]))
    else $error("clock compensation skip not written");
  // R2 gap checker skip
  a_gap_skip_set: assert property ( // R2
    wr_bypass |=> gap_checker_skip_out == $past(reg_wdata_in[14]))
    else $error("gap checker skip not written");
  // R3 lane order
  a_decoder_lanes: assert property ( // R3
    wr_bypass |=> decoder_skip_out == $past(reg_wdata_in[11:8]))
    else $error("decoder skip lanes wrong");
  // R4 sequence in gap
  a_seq_gap_sel: assert property ( // R4
    wr_bypass |=> seq_in_gap_out == $past(reg_wdata_in[7]))
    else $error("sequence column select wrong");
  // R5 alignment skip
  a_align_skip_set: assert property ( // R5
    wr_bypass ##1 !wr_bypass[*2] |-> align_skip_out == $past(reg_wdata_in[3], 2))
    else $error("lane alignment skip not held");
  // R6 312 flag latch
  a_stall_312_flag: assert property ( // R6
    (st_ff.idle_cnt[7] == 8'hFF) |=> st_ff.flags[7])
    else $error("312 clock stall flag not set");
  // R7 156 flag latch
  a_stall_156_flag: assert property ( // R7
    (st_ff.idle_cnt[0] == 8'hFF) |=> st_ff.flags[0])
    else $error("156 clock stall flag not set");
  // R8 transmit reset pulse
  a_tx_reset_pulse: assert property ( // R8
    wr_reset && reg_wdata_in[15] ##1 !(wr_reset && reg_wdata_in[15])
      |-> tx_path_reset_out ##1 !tx_path_reset_out)
    else $error("transmit reset did not self-clear");
  // R9 receive reset keeps registers
  a_rx_reset_keep: assert property ( // R9
    wr_reset && reg_wdata_in[14] |=> rx_path_reset_out && $stable(st_ff.bypass))
    else $error("receive reset wrong");
  // R9 receive reset pulse
  a_rx_reset_pulse: assert property ( // R9
    wr_reset && reg_wdata_in[14] ##1 !(wr_reset && reg_wdata_in[14])
      |-> rx_path_reset_out ##1 !rx_path_reset_out)
    else $error("receive reset did not self-clear");
  // R10 mux reset pulse
  a_mux_reset_pulse: assert property ( // R10
    wr_reset && reg_wdata_in[13] ##1 !(wr_reset && reg_wdata_in[13])
      |-> retimer_mux_reset_out ##1 !retimer_mux_reset_out)
    else $error("mux reset did not self-clear");
  // R11 sync readback
  a_sync_readback: assert property ( // R11
    reg_rd_in && reg_addr_in == XPBS_ADDR_PATTERN
      |=> reg_rvalid_out && reg_rdata_out[15] == $past(pattern_sync_in))
    else $error("sync flag readback wrong");
  // R12 flags hold without read
  a_flag_hold: assert property ( // R12
    !rd_flags |=> (st_ff.flags & $past(st_ff.flags)) == $past(st_ff.flags))
    else $error("clock down flag lost without read");
  // R13 unmapped read zero
  a_unmapped_zero: assert property ( // R13
    reg_rd_in && (reg_addr_in < XPBS_ADDR_BYPASS
      || reg_addr_in > XPBS_ADDR_PATTERN) |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  // R1 skip holds between writes
  a_ctc_skip_hold: assert property ( // R1
    !wr_bypass |=> $stable(rx_clock_comp_skip_out))
    else $error("clock compensation skip changed without write");
  // R2 gap skip holds
  a_gap_skip_hold: assert property ( // R2
    !wr_bypass |=> $stable(gap_checker_skip_out))
    else $error("gap checker skip changed without write");
  // R3 decoder skips hold
  a_decoder_hold: assert property ( // R3
    !wr_bypass |=> $stable(decoder_skip_out))
    else $error("decoder skip changed without write");
  // R4 sequence select holds
  a_seq_gap_hold: assert property ( // R4
    !wr_bypass |=> $stable(seq_in_gap_out))
    else $error("sequence column select changed without write");
  // R6 every stalled clock flagged
  a_stall_all_lanes: assert property ( // R6
    (st_ff.flags & $past(stalled)) == $past(stalled))
    else $error("stalled clock not flagged");
  // R7 156 lane 1 flag
  a_stall_156_lane1: assert property ( // R7
    (st_ff.idle_cnt[1] == XPBS_STALL_CYCLES) |=> st_ff.flags[1])
    else $error("156 clock lane 1 stall flag not set");
  // R8 no pulse without write
  a_reset_idle: assert property ( // R8
    !wr_reset |=> !tx_path_reset_out && !rx_path_reset_out
      && !retimer_mux_reset_out)
    else $error("soft reset pulse without write");
  // R12 read clears idle flags
  a_flag_clear_read: assert property ( // R12
    rd_flags && (stalled == 8'h00) |=> st_ff.flags == 8'h00)
    else $error("clock down flags not cleared by read");
  // R13 read always answered
  a_read_answer: assert property ( // R13
    reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");
  // R13 quiet bus idle
  a_idle_bus_zero: assert property ( // R13
    !reg_rd_in |=> !reg_rvalid_out && reg_rdata_out == 16'h0000)
    else $error("read data without read");
endmodule : xpbs_regs

// File: tb/xpbs_mgmt.sv
// Management station model driving the register strobe port
`timescale 1ns/1ps
module xpbs_mgmt (
  input wire logic clk_in,
  output logic [15:0] addr_out,
  output logic [15:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  initial begin
    addr_out = 16'h0000;
    wdata_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  task automatic access(input logic w, input logic [15:0] a,
                        input logic [15:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = w;
    rd_out = !w;
    @(negedge clk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    // Released address shows no stale value
    addr_out = ~a;
  endtask : access
endmodule : xpbs_mgmt

// File: tb/tb_top.sv
// Self-checking bench for the bypass and status register bank
`timescale 1ns/1ps
module tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] c312 = 4'h0;
  logic [3:0] c156 = 4'h0;
  logic sync = 1'b0;
  logic [7:0] alive = 8'hFF;
  logic [15:0] addr, wdata, rdata;
  logic wr, rd, rvalid, ccs, gcs, sig, als, txr, rxr, mxr;
  logic [3:0] dcs;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  initial forever #5 clk_in = ~clk_in;
  always @(negedge clk_in) begin
    c312 <= c312 ^ alive[7:4];
    c156 <= c156 ^ alive[3:0];
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      report_and_stop();
    end
  end
  xpbs_mgmt u_mgmt (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd));
  xpbs_regs u_dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .tx_clk312_toggle_in(c312), .tx_clk156_toggle_in(c156),
    .pattern_sync_in(sync), .rx_clock_comp_skip_out(ccs),
    .gap_checker_skip_out(gcs), .decoder_skip_out(dcs),
    .seq_in_gap_out(sig), .align_skip_out(als), .tx_path_reset_out(txr),
    .rx_path_reset_out(rxr), .retimer_mux_reset_out(mxr));
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rchk(input logic [15:0] a, input logic [15:0] e);
    u_mgmt.access(1'b0, a, 16'h0000);
    chk($sformatf("read %h", a), e, rvalid ? rdata : 16'hDEAD);
  endtask : rchk
  task automatic t_bypass();
    u_mgmt.access(1'b1, 16'h801E, 16'hFFFF);
    chk("bypass outs", 16'h00FF, {8'h00, ccs, gcs, dcs, sig, als});
    rchk(16'h801E, 16'hCF88);
    u_mgmt.access(1'b1, 16'h801E, 16'h8208);
    u_mgmt.access(1'b1, 16'h801F, 16'hFFFF);
    chk("bypass outs", 16'h0089, {8'h00, ccs, gcs, dcs, sig, als});
  endtask : t_bypass
  task automatic t_sreset();
    for (int i = 0; i < 3; i++) begin
      u_mgmt.access(1'b1, 16'h8020, 16'h2000 << i);
      chk("reset pulse", 16'h0001 << i, {13'h0000, txr, rxr, mxr});
      @(negedge clk_in);
      chk("reset end", 16'h0000, {13'h0000, txr, rxr, mxr});
    end
    rchk(16'h8020, 16'h0000);
    rchk(16'h801E, 16'h8208);
  endtask : t_sreset
  task automatic t_stall();
    // Lane 3 of 312 and lanes 1, 0 of 156 stop
    alive <= 8'h7C;
    repeat (240) @(negedge clk_in);
    rchk(16'h801F, 16'h0000);
    repeat (20) @(negedge clk_in);
    rchk(16'h801F, 16'h0083);
    alive <= 8'hFF;
    repeat (2) @(negedge clk_in);
    rchk(16'h801F, 16'h0083);
    rchk(16'h801F, 16'h0000);
  endtask : t_stall
  task automatic t_reset();
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    chk("rst skips", 16'h0000, {8'h00, ccs, gcs, dcs, sig, als});
    chk("rst pulses", 16'h0000, {13'h0000, txr, rxr, mxr});
    rchk(16'h801E, 16'h0000);
  endtask : t_reset
  task automatic report_and_stop();
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    for (int a = 0; a < 5; a++) rchk(16'h801E + 16'(a), 16'h0000);
    t_bypass();
    t_sreset();
    t_stall();
    t_reset();
    sync = 1'b1;
    rchk(16'h8021, 16'h8000);
    report_and_stop();
  end
endmodule : tb_top
